// ---- hdl/spc_serdes_port.v ----
`timescale 1ns/1ps
`default_nettype none
`include "spc_map.vh"

module spc_serdes_port (
  input wire i_clk,
  input wire i_rst_b,
  input wire i_ref_clk,
  input wire i_tx_word_clk,
  input wire [`SPC_WORD_W-1:0] i_tx_word,
  input wire i_tx_rate_select,
  input wire i_rx_rate_select,
  input wire i_legacy_rate_mode_n,
  input wire i_internal_loopback_en,
  input wire i_comma_detect_enable,
  input wire i_rx_p,
  input wire i_rx_n,
  output reg o_tx_word_ready,
  output reg o_tx_p,
  output reg o_tx_n,
  output reg [`SPC_WORD_W-1:0] o_rx_word,
  output reg o_recovered_word_clock,
  output reg o_recovered_word_clock_inv,
  output reg o_comma_found
);

  // One-hot serializer states
  localparam [1:0] TX_WAIT = 2'h1;
  localparam [1:0] TX_SEND = 2'h2;

  // Edge detectors on the two word-rate inputs
  // An input already high at release reads as a rise
  reg ref_prev_reg;
  reg txclk_prev_reg;
  wire ref_rise;
  wire txclk_rise;
  assign ref_rise = i_ref_clk & ~ref_prev_reg;
  assign txclk_rise = i_tx_word_clk & ~txclk_prev_reg;

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ref_prev_reg <= 1'b0;
      txclk_prev_reg <= 1'b0;
    end else begin
      ref_prev_reg <= i_ref_clk;
      txclk_prev_reg <= i_tx_word_clk;
    end
  end

  // Effective rates
  // Receive select is ignored in legacy mode
  wire tx_full;
  wire rx_full;
  assign tx_full = i_tx_rate_select;
  assign rx_full = i_legacy_rate_mode_n ? i_rx_rate_select : i_tx_rate_select;

  // Two-entry transmit buffer
  // A push while full is dropped; ready is already low
  reg [`SPC_WORD_W-1:0] fifo_mem [0:`SPC_FIFO_DEPTH-1];
  reg fifo_wr_reg;
  reg fifo_rd_reg;
  reg [`SPC_FIFO_CNT_W-1:0] fifo_cnt_reg;
  reg [`SPC_FIFO_CNT_W-1:0] fifo_cnt_next;
  wire fifo_push;
  wire fifo_pop;
  wire [`SPC_WORD_W-1:0] fifo_head;

  assign fifo_push = txclk_rise & (fifo_cnt_reg != `SPC_FIFO_FULL);
  // one word drained per reference period
  assign fifo_pop = ref_rise & (fifo_cnt_reg != 2'h0);
  assign fifo_head = fifo_mem[fifo_rd_reg];

  genvar g;
  generate
    for (g = 0; g < `SPC_FIFO_DEPTH; g = g + 1) begin : gen_fifo
      always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          fifo_mem[g] <= `SPC_IDLE_WORD;
        end else if (fifo_push && (fifo_wr_reg == g)) begin
          fifo_mem[g] <= i_tx_word;
        end
      end
    end
  endgenerate

  always @* begin
    fifo_cnt_next = fifo_cnt_reg;
    if (fifo_push && !fifo_pop) begin
      fifo_cnt_next = fifo_cnt_reg + 2'h1;
    end else if (fifo_pop && !fifo_push) begin
      fifo_cnt_next = fifo_cnt_reg - 2'h1;
    end
  end

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fifo_wr_reg <= 1'b0;
      fifo_rd_reg <= 1'b0;
      fifo_cnt_reg <= 2'h0;
      o_tx_word_ready <= 1'b1;
    end else begin
      if (fifo_push) begin
        fifo_wr_reg <= ~fifo_wr_reg;
      end
      if (fifo_pop) begin
        fifo_rd_reg <= ~fifo_rd_reg;
      end
      fifo_cnt_reg <= fifo_cnt_next;
      // Stalls the controller before a word is lost
      o_tx_word_ready <= (fifo_cnt_next != `SPC_FIFO_FULL);
    end
  end

  // Transmit serializer
  // Reference edge mid-frame restarts with the next word
  // An empty buffer sends the idle word instead
  reg [1:0] tx_state_reg;
  reg tx_ph_reg;
  reg [`SPC_CNT_W-1:0] tx_cnt_reg;
  reg [`SPC_WORD_W-1:0] tx_sr_reg;
  reg tx_bit_reg;
  reg tx_evt_reg;
  wire tx_bit_en;
  // full rate slot each cycle, half every other
  assign tx_bit_en = tx_full | tx_ph_reg;

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_state_reg <= TX_WAIT;
      tx_ph_reg <= 1'b0;
      tx_cnt_reg <= 5'h00;
      tx_sr_reg <= `SPC_IDLE_WORD;
      tx_bit_reg <= 1'b0;
      tx_evt_reg <= 1'b0;
    end else begin
      tx_evt_reg <= 1'b0;
      tx_ph_reg <= ~tx_ph_reg;
      if (ref_rise) begin
        // reference edge starts twenty bit slots
        tx_state_reg <= TX_SEND;
        tx_ph_reg <= 1'b0;
        tx_cnt_reg <= 5'h00;
        if (fifo_pop) begin
          tx_bit_reg <= fifo_head[0];
          tx_sr_reg <= {1'b0, fifo_head[`SPC_WORD_W-1:1]};
        end else begin
          tx_bit_reg <= 1'b0;
          tx_sr_reg <= `SPC_IDLE_WORD;
        end
        tx_evt_reg <= 1'b1;
      end else begin
        case (tx_state_reg)
          TX_WAIT: begin
            tx_cnt_reg <= 5'h00;
          end
          TX_SEND: begin
            if (tx_bit_en) begin
              tx_bit_reg <= tx_sr_reg[0];
              tx_sr_reg <= {1'b0, tx_sr_reg[`SPC_WORD_W-1:1]};
              tx_evt_reg <= 1'b1;
              if (tx_cnt_reg == `SPC_LAST_BIT - 5'h01) begin
                tx_state_reg <= TX_WAIT;
              end
              tx_cnt_reg <= tx_cnt_reg + 5'h01;
            end
          end
          default: begin
            tx_state_reg <= TX_WAIT;
          end
        endcase
      end
    end
  end

  // Serial output pins
  // Reset value equals the parked state
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_tx_p <= 1'b1;
      o_tx_n <= 1'b0;
    end else if (i_internal_loopback_en) begin
      o_tx_p <= 1'b1;
      o_tx_n <= 1'b0;
    end else begin
      o_tx_p <= tx_bit_reg;
      o_tx_n <= ~tx_bit_reg;
    end
  end

  // Receive bit source
  // Sampler is single-ended; negative leg unused
  // Half rate uses alternate cycles of a free phase
  reg rx_ph_reg;
  wire rx_bit_en;
  wire rx_bit;
  wire rx_ext_unused;
  assign rx_ext_unused = i_rx_n;
  // loopback takes tx stream and its timing
  assign rx_bit_en = i_internal_loopback_en ? tx_evt_reg
                     : (rx_full | rx_ph_reg);
  assign rx_bit = i_internal_loopback_en ? tx_bit_reg : i_rx_p;

  // Deserializer and aligner
  reg [`SPC_WORD_W-1:0] rx_sr_reg;
  reg [`SPC_CNT_W-1:0] rx_cnt_reg;
  reg [`SPC_CNT_W-1:0] rclk_hi_reg;
  reg [`SPC_WORD_W-1:0] rx_sr_next;
  reg comma_seen;
  reg realign;
  reg word_done;

  always @* begin
    // new bit enters at the top, earliest drifts to bit 0
    rx_sr_next = {rx_bit, rx_sr_reg[`SPC_WORD_W-1:1]};
    comma_seen = (rx_sr_next[`SPC_COMMA_MSB:`SPC_COMMA_LSB]
                  == `SPC_COMMA_PAT);
    realign = i_comma_detect_enable & comma_seen
              & (rx_cnt_reg != `SPC_COMMA_END);
    // A realign swallows the word being counted
    word_done = ~realign & (rx_cnt_reg == `SPC_LAST_BIT);
  end

  // Bit position within the receive word
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_ph_reg <= 1'b0;
      rx_sr_reg <= `SPC_IDLE_WORD;
      rx_cnt_reg <= 5'h00;
    end else begin
      rx_ph_reg <= ~rx_ph_reg;
      if (rx_bit_en) begin
        rx_sr_reg <= rx_sr_next;
        if (realign) begin
          // Comma already fills bits 0..6 of the new word
          rx_cnt_reg <= `SPC_COMMA_NEXT;
        end else if (word_done) begin
          rx_cnt_reg <= 5'h00;
        end else begin
          rx_cnt_reg <= rx_cnt_reg + 5'h01;
        end
      end
    end
  end

  // Parallel outputs and recovered word clock
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rclk_hi_reg <= 5'h00;
      o_rx_word <= `SPC_IDLE_WORD;
      o_recovered_word_clock <= 1'b0;
      o_recovered_word_clock_inv <= 1'b1;
      o_comma_found <= 1'b0;
    end else begin
      if (rx_bit_en && word_done) begin
        rclk_hi_reg <= 5'h00;
        // word and flag set up with clock rise
        o_rx_word <= rx_sr_next;
        // rising edge marks a new word
        o_recovered_word_clock <= 1'b1;
        o_recovered_word_clock_inv <= 1'b0;
        o_comma_found <= i_comma_detect_enable
                         & (rx_sr_next[6:0] == `SPC_COMMA_PAT);
      end else if (rx_bit_en && o_recovered_word_clock) begin
        // high for ten bits; counted apart from the
        // word position so a realign cannot cut it short
        rclk_hi_reg <= rclk_hi_reg + 5'h01;
        if (rclk_hi_reg == `SPC_MID_BIT) begin
          o_recovered_word_clock <= 1'b0;
          o_recovered_word_clock_inv <= 1'b1;
        end
      end
      if (!i_comma_detect_enable) begin
        o_comma_found <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ---- hdl/spc_map.vh ----
`ifndef SPC_MAP_VH
`define SPC_MAP_VH

// Parallel word width and bit counter width
`define SPC_WORD_W 20
`define SPC_CNT_W 5
// Bit counter values
`define SPC_LAST_BIT 5'h13
`define SPC_MID_BIT 5'h09
`define SPC_COMMA_END 5'h06
`define SPC_COMMA_NEXT 5'h07
// Comma sits in bits 6..0 as 1111100 (bit 0 first on the line)
`define SPC_COMMA_PAT 7'h7c
`define SPC_COMMA_MSB 19
`define SPC_COMMA_LSB 13
// Sent when no word is waiting at a frame start
`define SPC_IDLE_WORD 20'h00000
// Transmit buffer
`define SPC_FIFO_DEPTH 2
`define SPC_FIFO_CNT_W 2
`define SPC_FIFO_FULL 2'h2

`endif

// ---- verif/spc_serdes_port_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module spc_serdes_port_props (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ref_clk,
  input wire logic i_tx_word_clk,
  input wire logic i_internal_loopback_en,
  input wire logic i_comma_detect_enable,
  input wire logic o_tx_word_ready,
  input wire logic o_tx_p,
  input wire logic o_tx_n,
  input wire logic [19:0] o_rx_word,
  input wire logic o_recovered_word_clock,
  input wire logic o_recovered_word_clock_inv,
  input wire logic o_comma_found
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  a_tx_parked: assert property (i_internal_loopback_en [*2] |->
    o_tx_p && !o_tx_n) else $error("tx pins not parked");
  a_tx_pair: assert property (!i_internal_loopback_en [*2] |->
    o_tx_n == !o_tx_p) else $error("tx pair not complementary");
  a_ready_fall: assert property ($fell(o_tx_word_ready) |->
    $past(i_tx_word_clk) && !$past(i_tx_word_clk, 2))
    else $error("ready fell without push");
  a_ready_rise: assert property ($rose(o_tx_word_ready) |->
    $past(i_ref_clk) && !$past(i_ref_clk, 2))
    else $error("ready rose without pop");
  a_word_marks: assert property ($changed(o_rx_word) |->
    $rose(o_recovered_word_clock)) else $error("word without clock");
  a_rclk_high: assert property ($rose(o_recovered_word_clock) |->
    o_recovered_word_clock [*8]) else $error("clock pulse short");
  a_rclk_inv: assert property (o_recovered_word_clock_inv ==
    !o_recovered_word_clock) else $error("clock pair broken");
  a_comma_pat: assert property (o_comma_found |->
    o_rx_word[6:0] == 7'h7c) else $error("comma flag wrong");
  a_comma_gate: assert property (!i_comma_detect_enable |=>
    !o_comma_found) else $error("comma flag while disabled");
endmodule
`default_nettype wire

// ---- verif/spc_ctl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module spc_ctl_model (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_half,
  input wire logic i_hold,
  output logic o_ref_clk,
  output logic o_tx_word_clk,
  output logic o_frame
);
  logic [5:0] cnt_reg;
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) cnt_reg <= 6'h00;
    else if (cnt_reg == (i_half ? 6'h27 : 6'h13)) cnt_reg <= 6'h00;
    else cnt_reg <= cnt_reg + 6'h01;
  end
  // Hold stalls only the pop side
  assign o_tx_word_clk = cnt_reg < 6'h05;
  assign o_ref_clk = o_tx_word_clk && !i_hold;
  assign o_frame = cnt_reg == 6'h00;
endmodule
`default_nettype wire

// ---- verif/spc_serdes_port_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module spc_serdes_port_tb_top;
  localparam logic [19:0] W = 20'h5a37c;
  logic clk = 1'b0, rst_b = 1'b0, txs = 1'b1, rxs = 1'b1, leg_n = 1'b1;
  logic loop = 1'b0, cen = 1'b1, hold = 1'b0, rx_p = 1'b0, half = 1'b0;
  logic ph = 1'b0, ref_c, txc, frame, rdy, tp, tn, rc, rci, cf;
  logic [19:0] rw;
  logic [4:0] idx = 5'h00;
  int err_count = 0, n_checks = 0;
  spc_ctl_model ctl_u (.i_clk(clk), .i_rst_b(rst_b), .i_half(!txs),
    .i_hold(hold), .o_ref_clk(ref_c), .o_tx_word_clk(txc), .o_frame(frame));
  spc_serdes_port dut_u (.i_clk(clk), .i_rst_b(rst_b), .i_ref_clk(ref_c),
    .i_tx_word_clk(txc), .i_tx_word(W), .i_tx_rate_select(txs),
    .i_rx_rate_select(rxs), .i_legacy_rate_mode_n(leg_n),
    .i_internal_loopback_en(loop), .i_comma_detect_enable(cen),
    .i_rx_p(rx_p), .i_rx_n(!rx_p), .o_tx_word_ready(rdy), .o_tx_p(tp),
    .o_tx_n(tn), .o_rx_word(rw), .o_recovered_word_clock(rc),
    .o_recovered_word_clock_inv(rci), .o_comma_found(cf));
  initial forever #50 clk = !clk;
  // Bit 0 first; noise when looped
  always @(posedge clk) begin
    ph <= half ? !ph : 1'b0;
    if (loop) rx_p <= !rx_p;
    else if (!ph) begin
      rx_p <= W[idx];
      idx <= (idx == 5'h13) ? 5'h00 : idx + 5'h01;
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [19:0] e, g);
    n_checks++;
    if (e !== g) begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic watch(input int n, output int rises);
    logic prv;
    int i;
    rises = 0;
    prv = rc;
    for (i = 0; i < n; i++) begin
      cyc(1);
      if (rc === 1'b1 && prv === 1'b0) rises++;
      prv = rc;
    end
  endtask
  task automatic wfr;
    int k;
    cyc(1);
    for (k = 0; k < 100 && frame !== 1'b1; k++) cyc(1);
    if (frame !== 1'b1) begin
      err_count++;
      tally_and_finish;
    end
  endtask
  task automatic set(input logic l, t, r, lp, ce);
    @(posedge clk);
    leg_n <= l;
    txs <= t;
    rxs <= r;
    loop <= lp;
    cen <= ce;
    half <= !(l ? r : t);
  endtask
  task automatic t_tx(input logic s);
    logic [19:0] got;
    int i;
    set(1'b1, s, s, 1'b0, 1'b1);
    repeat (3) wfr;
    cyc(s ? 2 : 3);
    for (i = 0; i < 20; i++) begin
      got[i] = tp;
      cyc(s ? 1 : 2);
    end
    chk("tx serial", W, got);
  endtask
  task automatic t_rx(input logic l, t, r, ce);
    int nr;
    set(l, t, r, 1'b0, ce);
    watch(240, nr);
    chk("rx clock", 20'h1, {19'h0, nr > 2});
    chk("rx word", W, rw);
    chk("comma", {19'h0, ce}, {19'h0, cf});
  endtask
  task automatic t_loop;
    int nr;
    set(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    watch(240, nr);
    chk("loop clock", 20'h1, {19'h0, nr > 2});
    chk("loop word", W, rw);
    chk("tx park", 20'h2, {18'h0, tp, tn});
  endtask
  task automatic t_fill;
    set(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    hold <= 1'b1;
    repeat (3) wfr;
    chk("ready full", 20'h0, {19'h0, rdy});
    @(posedge clk);
    hold <= 1'b0;
    repeat (2) wfr;
    chk("ready drain", 20'h1, {19'h0, rdy});
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_tx(1'b1);
    t_tx(1'b0);
    t_rx(1'b1, 1'b1, 1'b0, 1'b1);
    t_rx(1'b1, 1'b0, 1'b1, 1'b1);
    t_rx(1'b0, 1'b1, 1'b0, 1'b1);
    t_rx(1'b0, 1'b0, 1'b1, 1'b1);
    t_rx(1'b0, 1'b0, 1'b1, 1'b0);
    t_loop;
    t_fill;
    tally_and_finish;
  end
endmodule
bind spc_serdes_port spc_serdes_port_props props_u (.i_clk(i_clk),
  .i_rst_b(i_rst_b), .i_ref_clk(i_ref_clk), .i_tx_word_clk(i_tx_word_clk),
  .i_internal_loopback_en(i_internal_loopback_en),
  .i_comma_detect_enable(i_comma_detect_enable),
  .o_tx_word_ready(o_tx_word_ready), .o_tx_p(o_tx_p), .o_tx_n(o_tx_n),
  .o_rx_word(o_rx_word), .o_recovered_word_clock(o_recovered_word_clock),
  .o_recovered_word_clock_inv(o_recovered_word_clock_inv),
  .o_comma_found(o_comma_found));
`default_nettype wire
